// >>> src/eli_pkg.sv
// constants, register map and types of the error led indicator
package eli_pkg;

  // timing
  localparam int CLK_KHZ       = 125000;
  localparam int FAST_HALF_MS  = 500;
  localparam int FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;
  localparam int WARN_HOLD_S   = 60;
  localparam int TB_W          = 26;

  // register byte offsets
  localparam logic [7:0] REG_USER_ERR  = 8'h00;
  localparam logic [7:0] REG_HOLD_TIME = 8'h04;
  localparam logic [7:0] REG_SCRIPT    = 8'h08;
  localparam logic [7:0] REG_CTRL      = 8'h0c;
  localparam logic [7:0] REG_STATUS    = 8'h10;
  localparam logic [7:0] REG_IRQ_STAT  = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK  = 8'h18;

  // fields and reset values
  localparam int          SCRIPT_RED_BIT   = 4;
  localparam int          SCRIPT_GREEN_BIT = 5;
  localparam int          CTRL_CFG_BIT     = 0;
  localparam logic [15:0] HOLD_RST         = 16'h000a;
  localparam logic [5:0]  SCRIPT_RST       = 6'h00;

  // interrupt status bits
  localparam int IRQ_SERIOUS = 0;
  localparam int IRQ_WARN    = 1;
  localparam int IRQ_USER    = 2;
  localparam int IRQ_EXPIRE  = 3;
  localparam int IRQ_W       = 4;

  // fault codes
  localparam logic [3:0] CODE_NONE        = 4'h0;
  localparam logic [3:0] CODE_SERIOUS_MAX = 4'h5;

  typedef enum logic [1:0] {
    DISP_IDLE,
    DISP_SERIOUS,
    DISP_WARN,
    DISP_USER
  } eli_disp_t;

endpackage

// >>> src/eli_ifs.sv
// carriers between the indicator's own modules
`timescale 1ns/10ps
interface eli_time_if;
  logic half_tick;
  logic sec_tick;
  logic fast_ph;
  logic slow_ph;
  modport src (output half_tick, sec_tick, fast_ph, slow_ph);
  modport snk (input  half_tick, sec_tick, fast_ph, slow_ph);
endinterface // eli_time_if

interface eli_bus_if;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr_stb;
  logic [31:0] rdata;
  logic        hit;
  modport slv  (output addr, wdata, wr_stb, input rdata, hit);
  modport regs (input addr, wdata, wr_stb, output rdata, hit);
endinterface // eli_bus_if

// >>> src/eli_timebase.sv
// flash phases and second tick
`timescale 1ns/10ps
module eli_timebase
  import eli_pkg::*;
#(
  parameter int HALF_CYC = FAST_HALF_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  eli_time_if.src  tb
);
  logic [TB_W-1:0] cnt_q;
  logic            fast_q;
  logic            slow_q;

  assign tb.half_tick = (cnt_q == TB_W'(HALF_CYC - 1));
  assign tb.sec_tick  = tb.half_tick && fast_q;
  assign tb.fast_ph   = fast_q;
  assign tb.slow_ph   = slow_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (tb.half_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + TB_W'(1);
    end
  end

  // 1 hz square wave, and half of it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_q <= 1'b0;
      slow_q <= 1'b0;
    end else if (tb.half_tick) begin
      fast_q <= !fast_q;
      if (fast_q) begin
        slow_q <= !slow_q;
      end
    end
  end
endmodule // eli_timebase

// >>> src/eli_apb_slave.sv
// apb slave front end, zero wait states
`timescale 1ns/10ps
module eli_apb_slave
  import eli_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  eli_bus_if.slv           bus
);
  assign bus.addr   = paddr;
  assign bus.wdata  = pwdata;
  assign bus.wr_stb = psel && penable && pwrite && bus.hit;
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !bus.hit;

  // read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= bus.hit ? bus.rdata : 32'h0000_0000;
    end
  end
endmodule // eli_apb_slave

// >>> src/eli_error_led_top.sv
// error led indicator: fault codes on state and number leds
//
// Operation
// - fault: status red, code flashes 1 hz
// - codes 1..5 latch until power cycle
// - codes 6..15 clear after one minute
// - config mode: code pattern not meaningful
// - user errors flash at 0.5 hz
// - user error held for programmed time
// - serious codes 1..5, code 0 reserved
// - warning codes 6..15, some reserved
// - code in binary, weights 8 4 2 1
// - idle: leds follow script values, but in config mode status red flashes 1 hz and status green stays off
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module eli_error_led_top
  import eli_pkg::*;
#(
  parameter int HALF_CYC = FAST_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fault_valid,
  input  wire logic [3:0]  fault_code,
  output logic             status_red,
  output logic             status_green,
  output logic             code_led_weight_eight,
  output logic             code_led_weight_four,
  output logic             code_led_weight_two,
  output logic             code_led_weight_one,
  output logic             config_mode,
  output logic             irq
);

  logic              rst_s1_q;
  logic              rst_n_q;
  eli_disp_t         disp_q;
  eli_disp_t         disp_d;
  logic [3:0]        code_q;
  logic [3:0]        code_d;
  logic [15:0]       hold_cnt_q;
  logic [15:0]       hold_cnt_d;
  logic [3:0]        user_code_q;
  logic [15:0]       hold_q;
  logic [5:0]        script_q;
  logic              cfg_q;
  logic [IRQ_W-1:0]  irq_stat_q;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;
  logic [3:0]        leds_q;
  logic              red_q;
  logic              green_q;
  logic              ser_evt;
  logic              warn_evt;
  logic              user_trig;
  logic              expire;
  logic              phase_on;
  logic [16:0]       cnt_next;

  eli_time_if tb ();
  eli_bus_if  bus ();

  // power-on reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  eli_timebase #(
    .HALF_CYC (HALF_CYC)
  ) u_timebase (
    .clk   (clk),
    .rst_n (rst_n_q),
    .tb    (tb)
  );

  eli_apb_slave u_apb (
    .clk     (clk),
    .rst_n   (rst_n_q),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .bus     (bus)
  );

  // event classification
  assign ser_evt   = fault_valid && (fault_code != CODE_NONE)
                     && (fault_code <= CODE_SERIOUS_MAX);
  assign warn_evt  = fault_valid && (fault_code > CODE_SERIOUS_MAX);
  assign user_trig = bus.wr_stb && (bus.addr == REG_USER_ERR)
                     && (bus.wdata[3:0] != CODE_NONE);
  assign cnt_next  = {1'b0, hold_cnt_q} + 17'h0_0001;

  always_comb begin
    expire = 1'b0;
    if (tb.sec_tick) begin
      case (disp_q)
        DISP_WARN: expire = (cnt_next >= 17'(WARN_HOLD_S));
        DISP_USER: expire = (cnt_next >= {1'b0, hold_q});
        default:   expire = 1'b0;
      endcase
    end
  end

  // display state
  always_comb begin
    disp_d     = disp_q;
    code_d     = code_q;
    hold_cnt_d = hold_cnt_q;
    case (disp_q)
      DISP_SERIOUS: begin
        disp_d = DISP_SERIOUS;
      end
      DISP_IDLE, DISP_WARN, DISP_USER: begin
        if (ser_evt) begin
          disp_d = DISP_SERIOUS;
          code_d = fault_code;
        end else if (warn_evt) begin
          disp_d     = DISP_WARN;
          code_d     = fault_code;
          hold_cnt_d = 16'h0000;
        end else if (user_trig) begin
          disp_d     = DISP_USER;
          code_d     = bus.wdata[3:0];
          hold_cnt_d = 16'h0000;
        end else if (expire) begin
          disp_d     = DISP_IDLE;
          code_d     = CODE_NONE;
          hold_cnt_d = 16'h0000;
        end else if (tb.sec_tick && disp_q != DISP_IDLE) begin
          hold_cnt_d = cnt_next[15:0];
        end
      end
      default: begin
        disp_d = DISP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      disp_q     <= DISP_IDLE;
      code_q     <= CODE_NONE;
      hold_cnt_q <= 16'h0000;
    end else begin
      disp_q     <= disp_d;
      code_q     <= code_d;
      hold_cnt_q <= hold_cnt_d;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      user_code_q <= CODE_NONE;
      hold_q      <= HOLD_RST;
      script_q    <= SCRIPT_RST;
      cfg_q       <= 1'b0;
      irq_mask_q  <= '0;
    end else if (bus.wr_stb) begin
      case (bus.addr)
        REG_USER_ERR:  user_code_q <= bus.wdata[3:0];
        REG_HOLD_TIME: hold_q      <= bus.wdata[15:0];
        REG_SCRIPT:    script_q    <= bus.wdata[5:0];
        REG_CTRL:      cfg_q       <= bus.wdata[CTRL_CFG_BIT];
        REG_IRQ_MASK:  irq_mask_q  <= bus.wdata[IRQ_W-1:0];
        default:       cfg_q       <= cfg_q;
      endcase
    end
  end

  // sticky interrupt status, set beats clear
  always_comb begin
    irq_set              = '0;
    irq_set[IRQ_SERIOUS] = (disp_d == DISP_SERIOUS) && (disp_q != DISP_SERIOUS);
    irq_set[IRQ_WARN]    = (disp_q != DISP_SERIOUS) && !ser_evt && warn_evt;
    irq_set[IRQ_USER]    = (disp_d == DISP_USER) && user_trig;
    irq_set[IRQ_EXPIRE]  = (disp_d == DISP_IDLE) && (disp_q != DISP_IDLE);
    irq_clr              = '0;
    if (bus.wr_stb && bus.addr == REG_IRQ_STAT) begin
      irq_clr = bus.wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // register read mux
  always_comb begin
    bus.hit   = 1'b1;
    bus.rdata = 32'h0000_0000;
    case (bus.addr)
      REG_USER_ERR:  bus.rdata = {28'h000_0000, user_code_q};
      REG_HOLD_TIME: bus.rdata = {16'h0000, hold_q};
      REG_SCRIPT:    bus.rdata = {26'h000_0000, script_q};
      REG_CTRL:      bus.rdata = {31'h0000_0000, cfg_q};
      REG_STATUS:    bus.rdata = {24'h00_0000, cfg_q, disp_q == DISP_USER,
                                  disp_q == DISP_WARN, disp_q == DISP_SERIOUS,
                                  code_q};
      REG_IRQ_STAT:  bus.rdata = {28'h000_0000, irq_stat_q};
      REG_IRQ_MASK:  bus.rdata = {28'h000_0000, irq_mask_q};
      default:       bus.hit   = 1'b0;
    endcase
  end

  // led drivers
  assign phase_on = (disp_q == DISP_USER) ? tb.slow_ph : tb.fast_ph;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      leds_q  <= 4'h0;
      red_q   <= 1'b0;
      green_q <= 1'b0;
    end else if (disp_q != DISP_IDLE) begin
      leds_q  <= phase_on ? code_q : 4'h0;
      red_q   <= cfg_q ? tb.fast_ph : 1'b1;
      green_q <= 1'b0;
    end else begin
      leds_q  <= script_q[3:0];
      red_q   <= cfg_q ? tb.fast_ph : script_q[SCRIPT_RED_BIT];
      green_q <= cfg_q ? 1'b0 : script_q[SCRIPT_GREEN_BIT];
    end
  end

  assign code_led_weight_eight = leds_q[3];
  assign code_led_weight_four  = leds_q[2];
  assign code_led_weight_two   = leds_q[1];
  assign code_led_weight_one   = leds_q[0];
  assign status_red            = red_q;
  assign status_green          = green_q;
  assign config_mode           = cfg_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n_q);

  property p_fault_red;
    (disp_q != DISP_IDLE && !cfg_q) |=> (status_red && !status_green);
  endproperty
  a_fault_red: assert property (p_fault_red)
    else $error("fault shown without steady red");

  property p_serious_latch;
    (ser_evt && disp_q != DISP_SERIOUS) |=> (disp_q == DISP_SERIOUS) [*8];
  endproperty
  a_serious_latch: assert property (p_serious_latch)
    else $error("serious fault not latched");

  property p_warn_minute;
    (disp_q == DISP_WARN && tb.sec_tick && hold_cnt_q == 16'(WARN_HOLD_S - 1)
     && !fault_valid && !user_trig) |=> (disp_q == DISP_IDLE);
  endproperty
  a_warn_minute: assert property (p_warn_minute)
    else $error("warning not cleared after one minute");

  property p_cfg_flash;
    (cfg_q && !tb.fast_ph && !(bus.wr_stb && bus.addr == REG_CTRL)) |=>
      (!status_red && !status_green && config_mode);
  endproperty
  a_cfg_flash: assert property (p_cfg_flash)
    else $error("config mode state led wrong");

  property p_user_slow;
    (disp_q == DISP_USER) |=>
      (leds_q == ($past(tb.slow_ph) ? $past(code_q) : 4'h0));
  endproperty
  a_user_slow: assert property (p_user_slow)
    else $error("user error not on slow phase");

  property p_user_hold;
    (disp_q == DISP_USER && tb.sec_tick && {1'b0, hold_cnt_q} + 17'h0_0001
     >= {1'b0, hold_q} && !fault_valid && !user_trig) |=> (disp_q == DISP_IDLE);
  endproperty
  a_user_hold: assert property (p_user_hold)
    else $error("user error not removed at hold time");

  property p_serious_code;
    (ser_evt && disp_q != DISP_SERIOUS) |=>
      (code_q == $past(fault_code) && irq_stat_q[IRQ_SERIOUS]);
  endproperty
  a_serious_code: assert property (p_serious_code)
    else $error("serious code not captured");

  property p_warn_enter;
    (warn_evt && disp_q != DISP_SERIOUS) |=>
      (disp_q == DISP_WARN && code_q == $past(fault_code) && hold_cnt_q == 16'h0000);
  endproperty
  a_warn_enter: assert property (p_warn_enter)
    else $error("warning not displayed");

  property p_binary;
    (disp_q inside {DISP_SERIOUS, DISP_WARN} && tb.fast_ph) |=>
      ({code_led_weight_eight, code_led_weight_four, code_led_weight_two,
        code_led_weight_one} == $past(code_q));
  endproperty
  a_binary: assert property (p_binary)
    else $error("code leds do not show code");

  property p_script;
    (disp_q == DISP_IDLE && !cfg_q) |=>
      (leds_q == $past(script_q[3:0]) && status_green == $past(script_q[SCRIPT_GREEN_BIT]));
  endproperty
  a_script: assert property (p_script)
    else $error("idle leds not following script");

  property p_serious_keep;
    (disp_q == DISP_SERIOUS) |=> (disp_q == DISP_SERIOUS && $stable(code_q));
  endproperty
  a_serious_keep: assert property (p_serious_keep)
    else $error("serious fault replaced");

  property p_cov_serious;
    ser_evt && disp_q == DISP_WARN;
  endproperty
  c_cov_serious: cover property (p_cov_serious);

  property p_cov_warn_exp;
    disp_q == DISP_WARN ##1 disp_q == DISP_IDLE;
  endproperty
  c_cov_warn_exp: cover property (p_cov_warn_exp);

  property p_cov_user_exp;
    disp_q == DISP_USER ##1 disp_q == DISP_IDLE;
  endproperty
  c_cov_user_exp: cover property (p_cov_user_exp);

  property p_cov_irq;
    $rose(irq);
  endproperty
  c_cov_irq: cover property (p_cov_irq);

endmodule // eli_error_led_top

// >>> dv/eli_led_viewer.sv
// led viewer model: decodes the number leds and measures flash on-time
`timescale 1ns/10ps
module eli_led_viewer (
  input  wire logic       clk,
  input  wire logic       clr,
  input  wire logic       cfg,
  input  wire logic [3:0] code_leds,
  output logic      [3:0] seen_code,
  output logic      [7:0] lit_len
);
  logic [7:0] run_q;

  // lit leds read as binary, weights 8 4 2 1
  always_ff @(posedge clk) begin
    if (clr) begin
      run_q     <= 8'h00;
      seen_code <= 4'h0;
      lit_len   <= 8'h00;
    end else if (cfg) begin
      run_q <= 8'h00;
    end else if (code_leds != 4'h0) begin
      run_q     <= run_q + 8'h01;
      seen_code <= code_leds;
    end else if (run_q != 8'h00) begin
      lit_len <= run_q;
      run_q   <= 8'h00;
    end
  end
endmodule // eli_led_viewer

// >>> dv/tb_error_led_indicator.sv
// testbench of the error led indicator
`timescale 1ns/10ps
module tb_error_led_indicator
  import eli_pkg::*;
;
  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fault_valid;
  logic [3:0]  fault_code;
  logic        status_red;
  logic        status_green;
  logic        num8;
  logic        num4;
  logic        num2;
  logic        num1;
  logic        config_mode;
  logic        irq;
  logic        vclr;
  logic [3:0]  seen_code;
  logic [7:0]  lit_len;
  logic [31:0] rd;
  logic        er;
  int          failures;
  int          comparisons;
  int          cycles;

  eli_error_led_top #(.HALF_CYC(10)) dut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_valid(fault_valid), .fault_code(fault_code),
    .status_red(status_red), .status_green(status_green),
    .code_led_weight_eight(num8), .code_led_weight_four(num4),
    .code_led_weight_two(num2), .code_led_weight_one(num1),
    .config_mode(config_mode), .irq(irq)
  );

  eli_led_viewer viewer (
    .clk(clk), .clr(vclr), .cfg(config_mode), .code_leds({num8, num4, num2, num1}),
    .seen_code(seen_code), .lit_len(lit_len)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stop_test();
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic fault(input logic [3:0] c);
    fault_valid <= 1'b1;
    fault_code  <= c;
    @(posedge clk);
    fault_valid <= 1'b0;
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    wt(2);
    resetn <= 1'b1;
    wt(4);
  endtask

  initial begin
    {resetn, psel, penable, pwrite, fault_valid} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fault_code = 4'h0;
    vclr = 1'b1;
    failures = 0;
    comparisons = 0;
    cycles = 0;
    @(posedge clk);
    do_reset();
    rchk("hold_rst", REG_HOLD_TIME, 32'h0000_000a);
    rchk("script_rst", REG_SCRIPT, 32'h0000_0000);
    rchk("mask_rst", REG_IRQ_MASK, 32'h0000_0000);
    rchk("unmapped", 8'h1c, 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, er});
    wr(REG_SCRIPT, 32'h0000_002b);
    wt(2);
    chk("script_leds", 32'h2b, {26'h0, status_green, status_red, num8, num4, num2, num1});
    fault(4'h0);
    wt(3);
    rchk("code0", REG_STATUS, 32'h0000_0000);
    wr(REG_IRQ_MASK, 32'h0000_000f);
    vclr <= 1'b0;
    fault(4'h9);
    wt(50);
    chk("warn_red", 32'h1, {31'h0, status_red});
    chk("warn_code", 32'h9, {28'h0, seen_code});
    chk("warn_flash", 32'd10, {24'h0, lit_len});
    chk("warn_irq", 32'h1, {31'h0, irq});
    rchk("warn_stat", REG_STATUS, 32'h0000_0029);
    wr(REG_IRQ_STAT, 32'h0000_000f);
    wt(2);
    chk("irq_clr", 32'h0, {31'h0, irq});
    wt(1100);
    rchk("warn_held", REG_STATUS, 32'h0000_0029);
    wt(117);
    rchk("warn_gone", REG_STATUS, 32'h0000_0000);
    rchk("expire_irq", REG_IRQ_STAT, 32'h0000_0008);
    chk("back_script", 32'h2b, {26'h0, status_green, status_red, num8, num4, num2, num1});
    wr(REG_IRQ_STAT, 32'h0000_000f);
    wr(REG_IRQ_MASK, 32'h0000_0000);
    wr(REG_HOLD_TIME, 32'h0000_0005);
    vclr <= 1'b1;
    wr(REG_USER_ERR, 32'h0000_0006);
    vclr <= 1'b0;
    wt(70);
    chk("user_code", 32'h6, {28'h0, seen_code});
    chk("user_flash", 32'd20, {24'h0, lit_len});
    chk("masked_irq", 32'h0, {31'h0, irq});
    rchk("user_stat", REG_STATUS, 32'h0000_0046);
    rchk("user_irqst", REG_IRQ_STAT, 32'h0000_0004);
    wt(40);
    rchk("user_gone", REG_STATUS, 32'h0000_0000);
    wr(REG_IRQ_STAT, 32'h0000_000f);
    wr(REG_IRQ_MASK, 32'h0000_0001);
    vclr <= 1'b1;
    fault(4'h3);
    vclr <= 1'b0;
    wt(3);
    fault(4'ha);
    wr(REG_USER_ERR, 32'h0000_0005);
    rchk("ser_keep", REG_STATUS, 32'h0000_0013);
    wt(1300);
    rchk("ser_latch", REG_STATUS, 32'h0000_0013);
    chk("ser_code", 32'h3, {28'h0, seen_code});
    chk("ser_flash", 32'd10, {24'h0, lit_len});
    chk("ser_red", 32'h1, {31'h0, status_red});
    chk("ser_irq", 32'h1, {31'h0, irq});
    wr(REG_CTRL, 32'h0000_0001);
    wt(2);
    chk("cfg_mode", 32'h1, {31'h0, config_mode});
    chk("cfg_green", 32'h0, {31'h0, status_green});
    rchk("cfg_stat", REG_STATUS, 32'h0000_0093);
    do_reset();
    rchk("pwr_cycle", REG_STATUS, 32'h0000_0000);
    chk("pwr_red", 32'h0, {31'h0, status_red});
    stop_test();
  end
endmodule // tb_error_led_indicator
